// *** hdl/rex_pkg.sv ***
/*
 * Constants for the instruction decode and execute block: opcode
 * patterns, field positions, widths and status bit positions.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
package rex_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 13;
    localparam int JUMP_W = 11;
    localparam int OSC_PER_CYCLE = 4;
    localparam int PHASE_W = 2;
    localparam int STACK_DEPTH = 8;
    // Field positions
    localparam int DEST_BIT = 7;
    localparam int BITSEL_LSB = 7;
    localparam int BITSEL_W = 3;
    // Opcode fields
    localparam logic [5:0] OP_ADD_ACC_FILE = 6'h07;
    localparam logic [5:0] OP_ZERO_GROUP = 6'h01;
    localparam logic [5:0] OP_INVERT_FILE = 6'h09;
    localparam logic [5:0] OP_DEC_FILE = 6'h03;
    localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
    localparam logic [5:0] OP_INC_SKIP = 6'h0f;
    localparam logic [5:0] OP_INC_FILE = 6'h0a;
    localparam logic [5:0] OP_OR_ACC_FILE = 6'h04;
    localparam logic [5:0] OP_OR_LITERAL = 6'h38;
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] BIT_CLEAR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_SKIP_LOW = 2'h2;
    localparam logic [1:0] BIT_SKIP_HIGH = 2'h3;
    localparam logic [13:0] WORD_ZERO_ACC = 14'h0103;
    localparam logic [13:0] WORD_WATCHDOG_KICK = 14'h0064;
    localparam logic [13:0] WORD_NOP = 14'h0000;
    // Status bit positions
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_POWER_DOWN = 3;
    localparam int ST_TIMEOUT = 4;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam int LATCH_LSB = 3;
    typedef enum logic [1:0] {
        REX_EXEC = 2'b00,
        REX_FLUSH = 2'b01
    } rex_state_type;
endpackage

// *** hdl/rex_stack.sv ***
/*
 * Return address stack, a small circular memory.
 */
`timescale 1ns/1ps
module rex_stack #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic push_i,
    input wire logic [WIDTH-1:0] push_data_i,
    output logic [WIDTH-1:0] top_o
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] ptr;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("Stack depth must be a power of two");
    end

    always_ff @(posedge clock_i) begin
        if (enable_i && push_i) begin
            mem[ptr] <= push_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            ptr <= '0;
        end else if (enable_i && push_i) begin
            ptr <= ptr + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            top_o <= '0;
        end else if (enable_i && push_i) begin
            top_o <= push_data_i;
        end
    end
endmodule // rex_stack

// *** hdl/rex_core.sv ***
/*
 * Decode and execute for the byte, bit, jump and literal instructions
 * add, bit clear/set/test, clear, call, watchdog kick, complement,
 * decrement, goto, increment and inclusive or.
 * Assumes program memory answers fetch_addr_o with insn_i within the same
 * instruction cycle, and the file register port reads combinationally.
 */
//
// Contract
// - Destination bit low writes accumulator, high writes the file.
// - Add accumulator and file, update carry, half carry and zero.
// - Bit clear op clears selected file bit, flags untouched.
// - Bit set op sets selected file bit, flags untouched.
// - Test skip if low skips next instruction when bit is zero.
// - Test skip if high skips next instruction when bit is one.
// - Taken skip discards prefetched word and runs a nop cycle.
// - Zero file op writes zero to file and sets zero flag.
// - Zero accumulator op clears accumulator and sets zero flag.
// - Call pushes next address, loads target and latch bits, two cycles.
// - Goto loads target and latch bits, two cycles, no push.
// - Watchdog kick zeroes timer and prescaler, sets both flags.
// - Invert file op writes complement, updates zero only.
// - Decrement writes file minus one, updates zero only.
// - Decrement skip writes result, no flags, skips on zero.
// - Increment skip writes result, no flags, skips on zero.
// - Increment writes file plus one wrapping, updates zero only.
// - Or literal ors literal into accumulator, updates zero.
// - Or accumulator file ors both to destination, updates zero.
// - Instruction cycle is four oscillator periods; second cycle nop.
`timescale 1ns/1ps
module rex_core #(
    parameter int STACK_DEPTH = rex_pkg::STACK_DEPTH
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic [rex_pkg::INSN_W-1:0] insn_i,
    input wire logic [rex_pkg::DATA_W-1:0] file_rdata_i,
    input wire logic [rex_pkg::DATA_W-1:0] pc_high_latch_i,
    output logic [rex_pkg::PC_W-1:0] fetch_addr_o,
    output logic [rex_pkg::FADDR_W-1:0] file_addr_o,
    output logic [rex_pkg::DATA_W-1:0] file_wdata_o,
    output logic file_we_o,
    output logic [rex_pkg::DATA_W-1:0] acc_o,
    output logic [rex_pkg::DATA_W-1:0] status_o,
    output logic [rex_pkg::PC_W-1:0] stack_top_o,
    output logic watchdog_clear_o,
    output logic cycle_strobe_o,
    output logic flushing_o
);
    import rex_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic [PHASE_W-1:0] phase;
    logic [PC_W-1:0] pc;
    logic [INSN_W-1:0] insn_q;
    rex_state_type state;
    rex_state_type next_state;
    logic step;
    logic [DATA_W-1:0] fval;
    logic [DATA_W-1:0] lit;
    logic [5:0] op6;
    logic [1:0] grp;
    logic [1:0] bop;
    logic [BITSEL_W-1:0] bsel;
    logic dest_file;
    logic [DATA_W-1:0] result;
    logic [DATA_W:0] sum9;
    logic [4:0] sum5;
    logic wr_acc;
    logic wr_file;
    logic upd_zero;
    logic upd_carry;
    logic skip;
    logic jump;
    logic push;
    logic kick;
    logic [PC_W-1:0] jump_target;

    if (STACK_DEPTH < 2) begin : g_depth_check
        $error("Stack depth too small");
    end

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == '0;
    endfunction

    // ****************************************
    // Instruction cycle phases
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            phase <= '0;
        end else if (enable_i) begin
            phase <= phase + 1'b1;
        end
    end

    assign step = enable_i && (phase == PHASE_W'(OSC_PER_CYCLE - 1));
    assign cycle_strobe_o = step;

    // ****************************************
    // Decode
    // ****************************************
    assign op6 = insn_q[13:8];
    assign grp = insn_q[13:12];
    assign bop = insn_q[11:10];
    assign bsel = insn_q[BITSEL_LSB +: BITSEL_W];
    assign dest_file = insn_q[DEST_BIT];
    assign lit = insn_q[DATA_W-1:0];
    assign fval = file_rdata_i;
    assign file_addr_o = insn_q[FADDR_W-1:0];
    assign sum9 = {1'b0, acc_o} + {1'b0, fval};
    assign sum5 = {1'b0, acc_o[3:0]} + {1'b0, fval[3:0]};
    assign jump_target = {pc_high_latch_i[LATCH_LSB +: 2],
                          insn_q[JUMP_W-1:0]};

    always_comb begin
        result = '0;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_zero = 1'b0;
        upd_carry = 1'b0;
        skip = 1'b0;
        jump = 1'b0;
        push = 1'b0;
        kick = 1'b0;
        if (state == REX_EXEC) begin
            if (insn_q == WORD_ZERO_ACC) begin
                result = '0;
                wr_acc = 1'b1;
                upd_zero = 1'b1;
            end else if (insn_q == WORD_WATCHDOG_KICK) begin
                kick = 1'b1;
            end else if (grp == GRP_BYTE) begin
                wr_acc = !dest_file;
                wr_file = dest_file;
                case (op6)
                    OP_ADD_ACC_FILE: begin
                        result = sum9[DATA_W-1:0];
                        upd_zero = 1'b1;
                        upd_carry = 1'b1;
                    end
                    OP_ZERO_GROUP: begin
                        result = '0;
                        wr_acc = 1'b0;
                        wr_file = dest_file;
                        upd_zero = dest_file;
                    end
                    OP_INVERT_FILE: begin
                        result = ~fval;
                        upd_zero = 1'b1;
                    end
                    OP_DEC_FILE: begin
                        result = fval - 1'b1;
                        upd_zero = 1'b1;
                    end
                    OP_DEC_SKIP: begin
                        result = fval - 1'b1;
                        skip = is_zero(result);
                    end
                    OP_INC_SKIP: begin
                        result = fval + 1'b1;
                        skip = is_zero(result);
                    end
                    OP_INC_FILE: begin
                        result = fval + 1'b1;
                        upd_zero = 1'b1;
                    end
                    OP_OR_ACC_FILE: begin
                        result = acc_o | fval;
                        upd_zero = 1'b1;
                    end
                    default: begin
                        wr_acc = 1'b0;
                        wr_file = 1'b0;
                    end
                endcase
            end else if (grp == GRP_BIT) begin
                result = fval;
                case (bop)
                    BIT_CLEAR: begin
                        result[bsel] = 1'b0;
                        wr_file = 1'b1;
                    end
                    BIT_SET: begin
                        result[bsel] = 1'b1;
                        wr_file = 1'b1;
                    end
                    BIT_SKIP_LOW: skip = !fval[bsel];
                    BIT_SKIP_HIGH: skip = fval[bsel];
                    default: skip = 1'b0;
                endcase
            end else if (grp == GRP_JUMP) begin
                jump = 1'b1;
                push = !insn_q[JUMP_W];
            end else if (op6 == OP_OR_LITERAL) begin
                result = acc_o | lit;
                wr_acc = 1'b1;
                upd_zero = 1'b1;
            end
        end
    end

    assign file_we_o = step && wr_file;
    assign file_wdata_o = result;
    assign watchdog_clear_o = step && kick;
    assign flushing_o = state == REX_FLUSH;

    // ****************************************
    // Sequencing
    // ****************************************
    always_comb begin
        case (state)
            REX_EXEC: next_state = (skip || jump) ? REX_FLUSH : REX_EXEC;
            REX_FLUSH: next_state = REX_EXEC;
            default: next_state = REX_EXEC;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            state <= REX_EXEC;
        end else if (step) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            insn_q <= WORD_NOP;
        end else if (step) begin
            insn_q <= (next_state == REX_FLUSH) ? WORD_NOP : insn_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            pc <= '0;
        end else if (step) begin
            pc <= jump ? jump_target : pc + 1'b1;
        end
    end

    assign fetch_addr_o = pc;

    // ****************************************
    // Accumulator and status
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            acc_o <= ACC_RESET;
        end else if (step && wr_acc) begin
            acc_o <= result;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            status_o <= STATUS_RESET;
        end else if (step) begin
            if (upd_zero) begin
                status_o[ST_ZERO] <= is_zero(result);
            end
            if (upd_carry) begin
                status_o[ST_CARRY] <= sum9[DATA_W];
                status_o[ST_HALF] <= sum5[4];
            end
            if (kick) begin
                status_o[ST_TIMEOUT] <= 1'b1;
                status_o[ST_POWER_DOWN] <= 1'b1;
            end
        end
    end

    rex_stack #(
        .WIDTH(PC_W),
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .enable_i(step),
        .push_i(push),
        .push_data_i(pc),
        .top_o(stack_top_o)
    );

    // ****************************************
    // Checks
    // ****************************************
    chk_flush_after_skip: assert property (@(posedge clock_i)
        disable iff (!reset_n_i) step && skip |=> state == REX_FLUSH)
        else $error("Skip did not insert a nop cycle");
    chk_flush_one_cycle: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        step && state == REX_FLUSH |=> state == REX_EXEC)
        else $error("Flush cycle lasted too long");
    chk_jump_target: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        step && jump |=> pc == $past(jump_target))
        else $error("Jump target not loaded");
    chk_call_push: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        step && push |=> stack_top_o == $past(pc))
        else $error("Call did not push return address");
    chk_zero_flag: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        step && upd_zero |=> status_o[ST_ZERO] == ($past(result) == 8'h00))
        else $error("Zero flag wrong");
    chk_kick_flags: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        step && kick |=> status_o[ST_TIMEOUT] && status_o[ST_POWER_DOWN])
        else $error("Kick did not set flags");
    chk_skip_flags_kept: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        step && skip |=> $stable(status_o))
        else $error("Skip changed status");
    chk_phase_period: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        step && enable_i |=> !step ##1 !step ##1 !step)
        else $error("Instruction cycle shorter than four periods");
    chk_dest_select: assert property (@(posedge clock_i)
        disable iff (!reset_n_i) !(wr_acc && wr_file))
        else $error("Both destinations written");
endmodule // rex_core

// *** bench/rex_mem_model.sv ***
/*
 * Program memory and file register model facing the decode block.
 * Assumes the bench preloads both arrays by hierarchical access.
 */
`timescale 1ns/1ps
module rex_mem_model (
    input wire logic clock_i,
    input wire logic [rex_pkg::PC_W-1:0] fetch_addr_i,
    output logic [rex_pkg::INSN_W-1:0] insn_o,
    input wire logic [rex_pkg::FADDR_W-1:0] file_addr_i,
    input wire logic [rex_pkg::DATA_W-1:0] file_wdata_i,
    input wire logic file_we_i,
    output logic [rex_pkg::DATA_W-1:0] file_rdata_o
);
    import rex_pkg::*;
    // ****************
    // Storage
    // ****************
    logic [INSN_W-1:0] rom [0:(1<<PC_W)-1];
    logic [DATA_W-1:0] ram [0:(1<<FADDR_W)-1];
    assign insn_o = rom[fetch_addr_i];
    assign file_rdata_o = ram[file_addr_i];
    always @(posedge clock_i) begin
        if (file_we_i) begin
            ram[file_addr_i] <= file_wdata_i;
        end
    end
endmodule // rex_mem_model

// *** bench/tb_top.sv ***
/*
 * Bench for rex_core: runs short programs and checks results.
 * Assumes rex_pkg, rex_core and rex_mem_model are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    import rex_pkg::*;
    // ****************
    // Harness
    // ****************
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [DATA_W-1:0] latch = 8'hf0;
    logic [INSN_W-1:0] insn;
    logic [DATA_W-1:0] rdata, wdata, acc, status;
    logic [PC_W-1:0] pc, top;
    logic [FADDR_W-1:0] faddr;
    logic we, kick, strobe, flush, kick_seen, first;
    logic enable = 1'b1;
    int fail_count = 0;
    int comparisons = 0;
    always #2.5 clock_i = ~clock_i;
    rex_core i_rex_core (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .enable_i(enable), .insn_i(insn), .file_rdata_i(rdata),
        .pc_high_latch_i(latch), .fetch_addr_o(pc), .file_addr_o(faddr),
        .file_wdata_o(wdata), .file_we_o(we), .acc_o(acc),
        .status_o(status), .stack_top_o(top), .watchdog_clear_o(kick),
        .cycle_strobe_o(strobe), .flushing_o(flush));
    rex_mem_model i_rex_mem_model (.clock_i(clock_i), .fetch_addr_i(pc),
        .insn_o(insn), .file_addr_i(faddr), .file_wdata_i(wdata),
        .file_we_i(we), .file_rdata_o(rdata));
    // ****************
    // Helpers
    // ****************
    task automatic results();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [13:0] bop(logic [5:0] op, logic d,
                                        logic [6:0] f);
        return {op, d, f};
    endfunction
    function automatic logic [13:0] bitop(logic [1:0] k, logic [2:0] b,
                                          logic [6:0] f);
        return {GRP_BIT, k, b, f};
    endfunction
    function automatic logic [13:0] orl(logic [7:0] k);
        return {OP_OR_LITERAL, k};
    endfunction
    task automatic wr(logic [6:0] a, logic [7:0] v);
        i_rex_mem_model.ram[a] = v;
    endtask
    task automatic restart(logic [13:0] p[$]);
        @(negedge clock_i);
        reset_n_i = 1'b0;
        for (int i = 0; i < (1 << PC_W); i++) begin
            i_rex_mem_model.rom[i] = WORD_NOP;
        end
        foreach (p[i]) i_rex_mem_model.rom[i] = p[i];
        repeat (16) @(negedge clock_i);
        reset_n_i = 1'b1;
        first = 1'b1;
    endtask
    task automatic steps(int n);
        int gap;
        kick_seen = 1'b0;
        for (int i = 0; i < n; i++) begin
            gap = 0;
            do begin
                @(negedge clock_i);
                gap++;
                if (gap > 20) begin
                    fail_count++;
                    $display("ERROR step wait ran out");
                    results();
                end
            end while (strobe !== 1'b1);
            kick_seen = kick_seen | kick;
            if (!first) check("step_gap", gap, OSC_PER_CYCLE);
            first = 1'b0;
        end
        @(posedge clock_i);
        #1;
    endtask
    task automatic sx(logic [7:0] a, logic z);
        steps(1);
        check("acc", acc, a);
        check("zero", status[ST_ZERO], z);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_add();
        wr(7'h10, 8'h81);
        wr(7'h11, 8'h71);
        restart('{orl(8'h8f), bop(OP_ADD_ACC_FILE, 1'b1, 7'h10),
                  bop(OP_ADD_ACC_FILE, 1'b0, 7'h11), orl(8'h80)});
        steps(3);
        check("acc", acc, 8'h8f);
        check("file", i_rex_mem_model.ram[7'h10], 8'h10);
        check("flags", status[2:0], 3'b011);
        steps(1);
        check("acc", acc, 8'h00);
        check("flags", status[2:0], 3'b111);
    endtask
    task automatic t_bits();
        wr(7'h20, 8'hc7);
        restart('{bitop(BIT_CLEAR, 3'd7, 7'h20), bitop(BIT_SET, 3'd3, 7'h20),
                  bitop(BIT_SKIP_LOW, 3'd4, 7'h20), orl(8'h01), orl(8'h02),
                  bitop(BIT_SKIP_HIGH, 3'd0, 7'h20), orl(8'h04), orl(8'h08),
                  bitop(BIT_SKIP_LOW, 3'd0, 7'h20), orl(8'h10), orl(8'h80)});
        steps(2);
        check("file", i_rex_mem_model.ram[7'h20], 8'h47);
        check("status", status, STATUS_RESET);
        steps(1);
        check("file", i_rex_mem_model.ram[7'h20], 8'h4f);
        check("status", status, STATUS_RESET);
        steps(1);
        check("flushing", flush, 1'b1);
        steps(7);
        check("acc", acc, 8'h1a);
    endtask
    task automatic t_byte();
        wr(7'h30, 8'h13);
        wr(7'h31, 8'h5a);
        wr(7'h32, 8'hff);
        wr(7'h33, 8'h91);
        restart('{bop(OP_INVERT_FILE, 1'b0, 7'h30), {OP_ZERO_GROUP, 8'hb1},
                  bop(OP_DEC_FILE, 1'b1, 7'h30), WORD_ZERO_ACC,
                  bop(OP_OR_ACC_FILE, 1'b0, 7'h33),
                  bop(OP_INC_FILE, 1'b1, 7'h32),
                  bop(OP_OR_ACC_FILE, 1'b1, 7'h30),
                  bop(OP_DEC_FILE, 1'b0, 7'h31)});
        steps(1);
        sx(8'hec, 1'b0);
        sx(8'hec, 1'b1);
        check("file", i_rex_mem_model.ram[7'h31], 8'h00);
        sx(8'hec, 1'b0);
        check("file", i_rex_mem_model.ram[7'h30], 8'h12);
        sx(8'h00, 1'b1);
        sx(8'h91, 1'b0);
        sx(8'h91, 1'b1);
        check("file", i_rex_mem_model.ram[7'h32], 8'h00);
        sx(8'h91, 1'b0);
        check("file", i_rex_mem_model.ram[7'h30], 8'h93);
        sx(8'hff, 1'b0);
    endtask
    task automatic t_skip();
        wr(7'h40, 8'h01);
        wr(7'h41, 8'hff);
        wr(7'h42, 8'h05);
        restart('{bop(OP_DEC_SKIP, 1'b1, 7'h40), orl(8'h01),
                  bop(OP_INC_SKIP, 1'b0, 7'h41), orl(8'h02),
                  bop(OP_DEC_SKIP, 1'b0, 7'h42), orl(8'h08), orl(8'h80)});
        steps(2);
        check("file", i_rex_mem_model.ram[7'h40], 8'h00);
        check("status", status, STATUS_RESET);
        steps(2);
        check("acc", acc, 8'h00);
        check("status", status, STATUS_RESET);
        steps(2);
        check("acc", acc, 8'h04);
        steps(1);
        check("acc", acc, 8'h0c);
    endtask
    task automatic t_jump();
        restart('{{GRP_JUMP, 1'b1, 11'h123}, orl(8'h40)});
        i_rex_mem_model.rom[13'h1123] = {GRP_JUMP, 1'b0, 11'h055};
        i_rex_mem_model.rom[13'h1124] = orl(8'h40);
        i_rex_mem_model.rom[13'h1055] = orl(8'h21);
        steps(2);
        check("pc", pc, 13'h1123);
        check("top", top, 13'h0000);
        check("flushing", flush, 1'b1);
        steps(2);
        check("pc", pc, 13'h1055);
        check("top", top, 13'h1124);
        check("acc", acc, 8'h00);
        steps(2);
        check("acc", acc, 8'h21);
    endtask
    task automatic t_kick();
        restart('{orl(8'h01), WORD_WATCHDOG_KICK, orl(8'h02)});
        steps(2);
        check("kick", kick_seen, 1'b0);
        check("acc", acc, 8'h01);
        steps(1);
        check("kick", kick_seen, 1'b1);
        check("flags", status[4:3], 2'b11);
        steps(1);
        check("kick", kick_seen, 1'b0);
        check("acc", acc, 8'h03);
    endtask
    task automatic t_hold();
        int seen;
        seen = 0;
        restart('{orl(8'h05), orl(8'h0a)});
        steps(2);
        check("acc", acc, 8'h05);
        @(negedge clock_i);
        enable = 1'b0;
        repeat (12) begin
            @(negedge clock_i);
            if (strobe !== 1'b0) seen++;
        end
        check("strobes", seen, 0);
        check("pc", pc, 13'h0002);
        check("acc", acc, 8'h05);
        enable = 1'b1;
        first = 1'b1;
        steps(1);
        check("acc", acc, 8'h0f);
    endtask
    initial begin
        t_add();
        t_bits();
        t_byte();
        t_skip();
        t_jump();
        t_kick();
        t_hold();
        results();
    end
endmodule // tb_top
